// file: rtl/cpm_top.sv
// clock and power-mode control: pll settings, power states, register port
// assumes an 8-bit register port on clk_i and asynchronous pins
`timescale 1ns/1ns
`include "cpm_defines.svh"
module cpm_top #(
  parameter int PWRUP_CYC   = `CPM_PWRUP_CYC,
  parameter int TRIM_TARGET = `CPM_TRIM_TGT
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  output logic      [7:0] rdata_o,
  // pins
  input  wire logic       power_down_pin_i,
  input  wire logic       lfo_clk_i,
  output logic            clock_output_pin_oe_o,
  // pll settings
  output logic      [7:0] feedback_ratio_o,
  output logic      [7:0] output_ratio_o,
  output logic      [7:0] lfo_trim_o,
  // analog and pad controls
  output logic            core_reg_on_o,
  output logic            osc_on_o,
  output logic            reg_stby_o,
  output logic            sinks_on_o,
  output logic            in_clamp_o,
  output logic            out_hiz_o,
  output logic            out_hold_o,
  output logic            tx_on_o,
  output logic            rx_on_o,
  output logic            rf_clk_en_o,
  output logic            ready_o
);
  import cpm_pkg::*;

  localparam cpm_top_st_t RST = '{
    pwr:     PS_OFF,
    fb:      `CPM_RST_FB,
    dout:    `CPM_RST_OUT,
    wuc_rel: `CPM_RST_WUC,
    default: '0
  };

  cpm_top_st_t q;
  cpm_top_st_t n;
  cpm_lfo_if   lnk ();
  logic        off_w;
  logic        stby_w;
  logic        run_w;
  logic        boot_w;
  logic        trip_w;
  logic        wr_w;

  function automatic logic fb_legal(input logic [7:0] v);
    fb_legal = (v == `CPM_FB_23) || (v == `CPM_FB_27) || (v == `CPM_FB_28);
  endfunction

  assign off_w  = (q.pwr == PS_OFF);
  assign stby_w = (q.pwr == PS_STBY);
  assign run_w  = (q.pwr == PS_RUN);
  assign boot_w = (q.pwr == PS_BOOT);
  // pin held high long enough to start the internal reset
  assign trip_w = q.pdn_s2 && (q.pdn_cnt == 8'(`CPM_PDN_CYC - 1));
  // clamped inputs ignore the port while powered down
  assign wr_w   = we_i && !off_w;

  always_comb
  begin
    n         = q;
    n.pdn_s1  = power_down_pin_i;
    n.pdn_s2  = q.pdn_s1;
    n.rdata   = 8'h00;
    if (!q.pdn_s2)
      n.pdn_cnt = 8'h00;
    else if (q.pdn_cnt != 8'(`CPM_PDN_CYC - 1))
      n.pdn_cnt = q.pdn_cnt + 8'h01;

    // register writes
    if (wr_w)
    begin
      unique case (addr_i)
        `CPM_A_CMD:  n.cmd = wdata_i;
        `CPM_A_CTRL: n.modem_off = wdata_i[0];
        `CPM_A_CLKO: n.clk_en = wdata_i[0];
        `CPM_A_FB:
          if (fb_legal(wdata_i))
            n.fb = wdata_i;
        `CPM_A_OUT:
          if (wdata_i != 8'h00)
            n.dout = wdata_i;
        `CPM_A_LCTL: n.lctl = wdata_i[`CPM_LCTL_AUTO:`CPM_LCTL_WUC];
        `CPM_A_WUC:  n.wuc_rel = wdata_i;
        `CPM_A_STAT:
          if (wdata_i[`CPM_STAT_WAKE])
            n.wake_flag = 1'b0;
        default: n.cmd = q.cmd;
      endcase
    end
    // a wake in the clearing cycle is kept
    if (lnk.wake)
      n.wake_flag = 1'b1;
    // timed wake from standby clears the request bit
    if (stby_w && lnk.wake && q.lctl[1])
      n.cmd[`CPM_CMD_STBY] = 1'b0;

    // register reads, data stand in the next cycle
    if (re_i && !off_w)
    begin
      unique case (addr_i)
        `CPM_A_CMD:  n.rdata = boot_w ? `CPM_NOT_READY : q.cmd;
        `CPM_A_CTRL: n.rdata = {7'h00, q.modem_off};
        `CPM_A_CLKO: n.rdata = {7'h00, q.clk_en};
        `CPM_A_FB:   n.rdata = q.fb;
        `CPM_A_OUT:  n.rdata = q.dout;
        `CPM_A_TRIM: n.rdata = lnk.trim;
        `CPM_A_LCTL: n.rdata = {5'h00, q.lctl, lnk.busy};
        `CPM_A_WUC:  n.rdata = q.wuc_rel;
        `CPM_A_STAT: n.rdata = {4'h0, stby_w, q.wake_flag, lnk.busy, run_w};
        default:     n.rdata = 8'h00;
      endcase
    end

    // power states
    unique case (q.pwr)
      PS_OFF:
        if (!q.pdn_s2)
        begin
          n.pwr      = PS_BOOT;
          n.boot_cnt = 16'(PWRUP_CYC - 1);
        end
      PS_BOOT:
        if (q.boot_cnt == 16'h0000)
          n.pwr = n.cmd[`CPM_CMD_STBY] ? PS_STBY : PS_RUN;
        else
          n.boot_cnt = q.boot_cnt - 16'h0001;
      PS_RUN:
        if (n.cmd[`CPM_CMD_STBY])
          n.pwr = PS_STBY;
      PS_STBY:
        if (!n.cmd[`CPM_CMD_STBY])
        begin
          n.pwr      = PS_BOOT;
          n.boot_cnt = 16'(`CPM_STBY_CYC - 1);
        end
    endcase

    // hard power-down: full reset of the register file
    if (off_w || trip_w)
    begin
      n         = RST;
      n.pdn_s1  = power_down_pin_i;
      n.pdn_s2  = q.pdn_s1;
      n.pdn_cnt = q.pdn_cnt;
      if (off_w && !q.pdn_s2)
      begin
        n.pwr      = PS_BOOT;
        n.boot_cnt = 16'(PWRUP_CYC - 1);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= RST;
    else
      q <= n;
  end

  // oscillator link
  assign lnk.run         = !off_w;
  assign lnk.trim_go     = wr_w && (addr_i == `CPM_A_LCTL) && wdata_i[`CPM_LCTL_GO];
  assign lnk.trim_wr     = wr_w && (addr_i == `CPM_A_TRIM);
  assign lnk.trim_wr_val = wdata_i;
  assign lnk.wuc_en      = q.lctl[0];
  assign lnk.wuc_reload  = q.wuc_rel;

  cpm_lfo #(
    .TRIM_TARGET (TRIM_TARGET)
  ) u_lfo (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .lfo_clk_i (lfo_clk_i),
    .lnk       (lnk)
  );

  // outputs
  assign rdata_o               = q.rdata;
  assign feedback_ratio_o      = q.fb;
  assign output_ratio_o        = q.dout;
  assign lfo_trim_o            = lnk.trim;
  assign clock_output_pin_oe_o = q.clk_en && !off_w;
  assign core_reg_on_o         = !off_w;
  assign osc_on_o              = !off_w;
  assign in_clamp_o            = off_w;
  assign out_hiz_o             = off_w;
  assign reg_stby_o            = stby_w;
  assign sinks_on_o            = !off_w && !stby_w;
  assign out_hold_o            = stby_w;
  assign tx_on_o               = run_w && !q.modem_off;
  assign rx_on_o               = run_w && !q.modem_off;
  assign rf_clk_en_o           = run_w;
  assign ready_o               = run_w;

  a_pdn_filter: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(off_w) |-> $past(q.pdn_s2) && $past(q.pdn_cnt) == 8'(`CPM_PDN_CYC - 1))
    else $error("power-down entered before pin held long enough");
  a_off_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    off_w |-> !core_reg_on_o && !osc_on_o && in_clamp_o && out_hiz_o && !clock_output_pin_oe_o)
    else $error("pads or regulators active in power-down");
  a_off_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    off_w |-> q.cmd == 8'h00 && q.fb == `CPM_RST_FB && q.dout == `CPM_RST_OUT && !q.clk_en)
    else $error("register kept its value in power-down");
  a_off_leave: assert property (@(posedge clk_i) disable iff (rst_i)
    off_w && !q.pdn_s2 |=> boot_w && q.boot_cnt == 16'(PWRUP_CYC - 1))
    else $error("start-up not begun after pin release");
  a_stby_enter: assert property (@(posedge clk_i) disable iff (rst_i)
    run_w && we_i && addr_i == `CPM_A_CMD && wdata_i[`CPM_CMD_STBY] && !trip_w |=> stby_w && !sinks_on_o)
    else $error("standby not entered at once");
  a_stby_pads: assert property (@(posedge clk_i) disable iff (rst_i)
    stby_w |-> out_hold_o && !in_clamp_o && !out_hiz_o)
    else $error("pads not held in standby");
  a_stby_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    stby_w && !we_i && !trip_w |=> $stable(q.fb) && $stable(q.dout) && $stable(q.clk_en))
    else $error("configuration changed in standby");
  a_stby_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    stby_w && we_i && addr_i == `CPM_A_CMD && !wdata_i[`CPM_CMD_STBY] && !trip_w |=>
      boot_w && q.boot_cnt == 16'(`CPM_STBY_CYC - 1))
    else $error("start-up not triggered by standby clear");
  a_boot_read: assert property (@(posedge clk_i) disable iff (rst_i)
    boot_w && re_i && addr_i == `CPM_A_CMD && !trip_w |=> rdata_o == `CPM_NOT_READY)
    else $error("command register returned during start-up");
  a_modem_off: assert property (@(posedge clk_i) disable iff (rst_i)
    run_w |-> (tx_on_o == !q.modem_off) && (rx_on_o == !q.modem_off))
    else $error("modem state differs from disable bit");
  a_fb_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    fb_legal(feedback_ratio_o) && output_ratio_o != 8'h00)
    else $error("illegal divider setting");
  a_clk_out: assert property (@(posedge clk_i) disable iff (rst_i)
    clock_output_pin_oe_o |-> q.clk_en)
    else $error("clock output driven while disabled");

  // power-down pin filter and full reset
  a_pdn_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.pdn_s2 && !off_w |=> q.pdn_cnt == 8'h00)
    else $error("power-down filter not cleared by low pin");
  a_pdn_count: assert property (@(posedge clk_i) disable iff (rst_i)
    q.pdn_s2 && !off_w && !trip_w |=> q.pdn_cnt == $past(q.pdn_cnt) + 8'h01)
    else $error("power-down filter skipped a sample");
  a_off_stay: assert property (@(posedge clk_i) disable iff (rst_i)
    off_w && q.pdn_s2 |=> off_w)
    else $error("power-down left while pin high");
  a_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    off_w |=> rdata_o == 8'h00)
    else $error("read data returned in power-down");
  a_lfo_off: assert property (@(posedge clk_i) disable iff (rst_i)
    off_w |=> !lnk.busy && !lnk.wake)
    else $error("oscillator logic active in power-down");
  a_trip_regs: assert property (@(posedge clk_i) disable iff (rst_i)
    trip_w |=> off_w && q.cmd == 8'h00 && q.lctl == 2'h0 && q.wuc_rel == `CPM_RST_WUC && !q.wake_flag)
    else $error("register kept on power-down entry");
  a_trip_lfo: assert property (@(posedge clk_i) disable iff (rst_i)
    trip_w |-> ##2 lnk.trim == `CPM_RST_TRIM && !lnk.busy)
    else $error("trim kept in power-down");

  // start-up sequence and ready reads
  a_boot_count: assert property (@(posedge clk_i) disable iff (rst_i)
    boot_w && q.boot_cnt != 16'h0000 && !trip_w |=> boot_w && q.boot_cnt == $past(q.boot_cnt) - 16'h0001)
    else $error("start-up counter skipped a step");
  a_boot_done: assert property (@(posedge clk_i) disable iff (rst_i)
    boot_w && q.boot_cnt == 16'h0000 && !trip_w |=> run_w || stby_w)
    else $error("start-up did not finish on time");
  a_run_pads: assert property (@(posedge clk_i) disable iff (rst_i)
    run_w |-> !in_clamp_o && !out_hiz_o && !out_hold_o && sinks_on_o && core_reg_on_o)
    else $error("pads not released in full operation");
  a_ready_read: assert property (@(posedge clk_i) disable iff (rst_i)
    run_w && re_i && addr_i == `CPM_A_CMD && !trip_w |=> rdata_o == $past(q.cmd))
    else $error("command register not returned when ready");
  a_read_once: assert property (@(posedge clk_i) disable iff (rst_i)
    !re_i |=> rdata_o == 8'h00)
    else $error("read data stood too long");
  a_rf_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_w |-> !rf_clk_en_o && !tx_on_o && !rx_on_o && !ready_o)
    else $error("time base on outside full operation");

  // divider and enable registers
  a_fb_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    we_i && addr_i == `CPM_A_FB && !fb_legal(wdata_i) && !trip_w |=> $stable(q.fb))
    else $error("illegal feedback ratio taken");
  a_fb_take: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_w && addr_i == `CPM_A_FB && fb_legal(wdata_i) && !trip_w |=> q.fb == $past(wdata_i))
    else $error("legal feedback ratio not taken");
  a_out_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    we_i && addr_i == `CPM_A_OUT && wdata_i == 8'h00 && !trip_w |=> $stable(q.dout))
    else $error("zero output ratio taken");
  a_out_take: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_w && addr_i == `CPM_A_OUT && wdata_i != 8'h00 && !trip_w |=> q.dout == $past(wdata_i))
    else $error("output ratio not taken");
  a_clk_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_w && addr_i == `CPM_A_CLKO && !trip_w |=> clock_output_pin_oe_o == $past(wdata_i[0]))
    else $error("clock output drive differs from enable write");
  a_modem_write: assert property (@(posedge clk_i) disable iff (rst_i)
    run_w && wr_w && addr_i == `CPM_A_CTRL && !trip_w |=> tx_on_o == !$past(wdata_i[0]) && rx_on_o == tx_on_o)
    else $error("modem state differs from disable write");

  // standby and timed wake
  a_stby_supply: assert property (@(posedge clk_i) disable iff (rst_i)
    stby_w |-> reg_stby_o && !sinks_on_o && core_reg_on_o && !ready_o)
    else $error("supplies not in standby");
  a_stby_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    stby_w && !we_i && !trip_w |=> $stable(clock_output_pin_oe_o) && $stable(q.modem_off))
    else $error("outputs changed in standby");
  a_stby_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
    stby_w && !we_i && !trip_w && !lnk.wake |=> stby_w && $stable(q.cmd))
    else $error("command register changed in standby");
  a_auto_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    stby_w && lnk.wake && q.lctl[1] && !trip_w |=> boot_w)
    else $error("timed wake did not start up");
  a_wake_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    lnk.wake && !off_w && !trip_w |=> q.wake_flag)
    else $error("wake not flagged");
  a_wake_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    q.wake_flag && !off_w && !trip_w && !(wr_w && addr_i == `CPM_A_STAT) |=> q.wake_flag)
    else $error("wake flag lost without clear");

  // oscillator link
  a_trim_start: assert property (@(posedge clk_i) disable iff (rst_i)
    lnk.trim_go && !lnk.busy && !trip_w |=> lnk.busy)
    else $error("trim not started");
  a_trim_load: assert property (@(posedge clk_i) disable iff (rst_i)
    lnk.trim_wr && !lnk.busy |=> lnk.trim == $past(lnk.trim_wr_val))
    else $error("trim write not taken");
  a_wuc_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(lnk.wuc_en) |-> !lnk.wake)
    else $error("wake while counter disabled");
endmodule

// file: inc/cpm_defines.svh
// constants of the clock and power-mode control block
// assumes a 10 MHz system clock and an 8-bit register port
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH
`define CPM_A_CMD     8'h00
`define CPM_A_CTRL    8'h01
`define CPM_A_CLKO    8'h02
`define CPM_A_FB      8'h03
`define CPM_A_OUT     8'h04
`define CPM_A_TRIM    8'h05
`define CPM_A_LCTL    8'h06
`define CPM_A_WUC     8'h07
`define CPM_A_STAT    8'h08
`define CPM_CMD_STBY  7
`define CPM_LCTL_GO   0
`define CPM_LCTL_WUC  1
`define CPM_LCTL_AUTO 2
`define CPM_STAT_WAKE 2
`define CPM_FB_23     8'h17
`define CPM_FB_27     8'h1b
`define CPM_FB_28     8'h1c
`define CPM_RST_FB    8'h17
`define CPM_RST_OUT   8'h4e
`define CPM_RST_TRIM  8'h80
`define CPM_RST_WUC   8'h10
`define CPM_NOT_READY 8'hff
`define CPM_CLK_MHZ   10
`define CPM_PDN_US    10
`define CPM_PDN_CYC   (`CPM_PDN_US * `CPM_CLK_MHZ)
`define CPM_STBY_US   15
`define CPM_STBY_CYC  (`CPM_STBY_US * `CPM_CLK_MHZ)
`define CPM_PWRUP_US  2500
`define CPM_PWRUP_CYC (`CPM_PWRUP_US * `CPM_CLK_MHZ)
`define CPM_LFO_HZ    16000
`define CPM_TRIM_PER  8
`define CPM_TRIM_TGT  ((`CPM_CLK_MHZ * 1000000 / `CPM_LFO_HZ) * `CPM_TRIM_PER)
`endif

// file: inc/cpm_pkg.sv
// types of the clock and power-mode control block
// assumes cpm_defines.svh for all numbers
package cpm_pkg;
  typedef enum logic [3:0] {
    PS_OFF  = 4'h1,
    PS_BOOT = 4'h2,
    PS_RUN  = 4'h4,
    PS_STBY = 4'h8
  } cpm_pwr_t;
  typedef enum logic [2:0] {
    TS_IDLE = 3'h1,
    TS_SYNC = 3'h2,
    TS_MEAS = 3'h4
  } cpm_trim_t;
  typedef struct packed {
    cpm_pwr_t    pwr;
    logic        pdn_s1;
    logic        pdn_s2;
    logic [7:0]  pdn_cnt;
    logic [15:0] boot_cnt;
    logic [7:0]  cmd;
    logic        modem_off;
    logic        clk_en;
    logic [7:0]  fb;
    logic [7:0]  dout;
    logic [1:0]  lctl;
    logic [7:0]  wuc_rel;
    logic        wake_flag;
    logic [7:0]  rdata;
  } cpm_top_st_t;
  typedef struct packed {
    logic        l1;
    logic        l2;
    logic        l3;
    cpm_trim_t   st;
    logic [3:0]  per;
    logic [15:0] ref_cnt;
    logic [7:0]  trim;
    logic [7:0]  wakeup_counter;
    logic        wake;
  } cpm_lfo_st_t;
endpackage

// file: inc/cpm_lfo_if.sv
// link between power control and the low-frequency oscillator logic
// assumes both ends on clk_i
`timescale 1ns/1ns
interface cpm_lfo_if;
  logic       run;
  logic       trim_go;
  logic       trim_wr;
  logic [7:0] trim_wr_val;
  logic [7:0] trim;
  logic       busy;
  logic       wuc_en;
  logic [7:0] wuc_reload;
  logic       wake;
  modport ctl (output run, trim_go, trim_wr, trim_wr_val, wuc_en, wuc_reload,
               input trim, busy, wake);
  modport lfo (input run, trim_go, trim_wr, trim_wr_val, wuc_en, wuc_reload,
               output trim, busy, wake);
endinterface

// file: rtl/cpm_lfo.sv
// low-frequency oscillator trim machine and wake-up counter
// assumes lfo_clk_i is an asynchronous pin from the oscillator
`timescale 1ns/1ns
`include "cpm_defines.svh"
module cpm_lfo #(
  parameter int TRIM_TARGET = `CPM_TRIM_TGT,
  parameter int TRIM_PER    = `CPM_TRIM_PER
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // oscillator pin
  input  wire logic lfo_clk_i,
  // control link
  cpm_lfo_if.lfo    lnk
);
  import cpm_pkg::*;
  localparam cpm_lfo_st_t RST = '{st: TS_IDLE, trim: `CPM_RST_TRIM, wakeup_counter: `CPM_RST_WUC, default: '0};
  cpm_lfo_st_t q;
  cpm_lfo_st_t n;
  logic        edge_w;

  assign edge_w = q.l2 & ~q.l3;

  always_comb
  begin
    n      = q;
    n.l1   = lfo_clk_i;
    n.l2   = q.l1;
    n.l3   = q.l2;
    n.wake = 1'b0;
    if (lnk.trim_wr)
      n.trim = lnk.trim_wr_val;
    // trim: count reference cycles across several lfo periods
    unique case (q.st)
      TS_IDLE: if (lnk.trim_go) n.st = TS_SYNC;
      TS_SYNC:
        if (edge_w)
        begin
          n.st      = TS_MEAS;
          n.per     = 4'h0;
          // the closing cycle counts too, so a true period matches the target
          n.ref_cnt = 16'h0001;
        end
      TS_MEAS:
      begin
        if (q.ref_cnt != 16'hffff)
          n.ref_cnt = q.ref_cnt + 16'h0001;
        if (edge_w)
        begin
          n.per = q.per + 4'h1;
          if (q.per == 4'(TRIM_PER - 1))
          begin
            n.st = TS_IDLE;
            if (q.ref_cnt > 16'(TRIM_TARGET) && q.trim != 8'hff)
              n.trim = q.trim + 8'h01;
            else if (q.ref_cnt < 16'(TRIM_TARGET) && q.trim != 8'h00)
              n.trim = q.trim - 8'h01;
          end
        end
      end
    endcase
    // periodic wake from the low-frequency clock
    if (!lnk.wuc_en)
      n.wakeup_counter = lnk.wuc_reload;
    else if (edge_w)
    begin
      if (q.wakeup_counter == 8'h00)
      begin
        n.wakeup_counter  = lnk.wuc_reload;
        n.wake = 1'b1;
      end
      else
        n.wakeup_counter = q.wakeup_counter - 8'h01;
    end
    if (!lnk.run)
      n = '{l1: n.l1, l2: n.l2, l3: n.l3, st: TS_IDLE, trim: `CPM_RST_TRIM, wakeup_counter: `CPM_RST_WUC, default: '0};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= RST;
    else
      q <= n;
  end

  assign lnk.trim = q.trim;
  assign lnk.busy = (q.st != TS_IDLE);
  assign lnk.wake = q.wake;

  a_trim_step: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(lnk.busy) && $past(lnk.run) && !$past(lnk.trim_wr) |->
      (q.trim - $past(q.trim)) inside {8'h00, 8'h01, 8'hff})
    else $error("trim moved more than one step");
  a_wuc_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    q.wake |-> $past(edge_w) && $past(q.wakeup_counter) == 8'h00 && $past(lnk.wuc_en))
    else $error("wake without counter expiry");
endmodule

// file: testbench/cpm_lfo_osc.sv
// behavioural oscillator seen at the lfo pin, 200 kHz at the default HALF_NS of 2500
// assumes the bench scales the period to keep the run short
`timescale 1ns/1ns
module cpm_lfo_osc #(
  parameter int HALF_NS = 2500
) (
  // oscillator pin
  output logic lfo_clk_o
);
  // free running, phase unrelated to the system clock
  initial
  begin
    lfo_clk_o = 1'b0;
    #37;
    forever #(HALF_NS) lfo_clk_o = ~lfo_clk_o;
  end
endmodule

// file: testbench/test_cpm_top.sv
// self-checking bench for the clock and power-mode control block
// assumes cpm_top on a 10 MHz clock and the lfo model beside it
`timescale 1ns/1ns
`include "cpm_defines.svh"
module test_cpm_top;
  import cpm_pkg::*;
  logic       clk_i;
  logic       rst_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       we_i;
  logic       re_i;
  logic [7:0] rdata_o;
  logic       pdn_i;
  logic       lfo_clk;
  logic       oe_o;
  logic [7:0] fb_o;
  logic [7:0] out_o;
  logic [7:0] trim_o;
  logic       core_reg_on_o, osc_on_o, reg_stby_o, sinks_on_o, in_clamp_o;
  logic       out_hiz_o, out_hold_o, tx_on_o, rx_on_o, rf_clk_en_o, ready_o;
  logic [7:0] pins;
  logic [7:0] rfv;
  logic [7:0] d;
  int         n_fail;
  int         comparisons;
  int         cycles;
  assign pins = {core_reg_on_o, in_clamp_o, out_hiz_o, oe_o, reg_stby_o, sinks_on_o, out_hold_o, ready_o};
  assign rfv  = {4'h0, osc_on_o, tx_on_o, rx_on_o, rf_clk_en_o};
  cpm_lfo_osc #(.HALF_NS(2500)) osc (.lfo_clk_o(lfo_clk));
  cpm_top #(.PWRUP_CYC(20), .TRIM_TARGET(500)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .power_down_pin_i(pdn_i), .lfo_clk_i(lfo_clk), .clock_output_pin_oe_o(oe_o),
    .feedback_ratio_o(fb_o), .output_ratio_o(out_o), .lfo_trim_o(trim_o), .core_reg_on_o(core_reg_on_o),
    .osc_on_o(osc_on_o), .reg_stby_o(reg_stby_o), .sinks_on_o(sinks_on_o), .in_clamp_o(in_clamp_o),
    .out_hiz_o(out_hiz_o), .out_hold_o(out_hold_o), .tx_on_o(tx_on_o), .rx_on_o(rx_on_o),
    .rf_clk_en_o(rf_clk_en_o), .ready_o(ready_o));
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task wrap_up;
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    we_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clk_i);
    we_i <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    re_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  task wait_ready(input int lim);
    int k;
    k = 0;
    while (ready_o !== 1'b1 && k < lim)
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk({7'h00, ready_o}, 8'h01);
  endtask
  // poll a status bit through reads
  task poll(input int b, input logic v, input int lim);
    int k;
    k = 0;
    rd(`CPM_A_STAT, d);
    while (d[b] !== v && k < lim)
    begin
      rd(`CPM_A_STAT, d);
      k++;
    end
    chk({7'h00, d[b]}, {7'h00, v});
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    rst_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    we_i = 1'b0;
    re_i = 1'b0;
    pdn_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk(pins, 8'h60);
    chk(rfv, 8'h00);
    chk(fb_o, `CPM_RST_FB);
    chk(out_o, `CPM_RST_OUT);
    chk(trim_o, `CPM_RST_TRIM);
    repeat (2) @(posedge clk_i);
    rd(`CPM_A_CMD, d);
    chk(d, `CPM_NOT_READY);
    wait_ready(40);
    rd(`CPM_A_CMD, d);
    chk(d, 8'h00);
    chk(pins, 8'h85);
    chk(rfv, 8'h0f);
    // feedback ratio: legal values taken, others refused
    wr(`CPM_A_FB, `CPM_FB_27);
    chk(fb_o, `CPM_FB_27);
    wr(`CPM_A_FB, 8'h20);
    chk(fb_o, `CPM_FB_27);
    wr(`CPM_A_FB, 8'h19);
    chk(fb_o, `CPM_FB_27);
    wr(`CPM_A_OUT, 8'h3d);
    chk(out_o, 8'h3d);
    wr(`CPM_A_OUT, 8'h00);
    chk(out_o, 8'h3d);
    wr(`CPM_A_FB, `CPM_FB_28);
    chk(fb_o, `CPM_FB_28);
    wr(`CPM_A_FB, `CPM_FB_23);
    chk(fb_o, `CPM_FB_23);
    wr(`CPM_A_FB, `CPM_FB_28);
    rd(8'h3f, d);
    chk(d, 8'h00);
    // clock output drive follows its enable
    wr(`CPM_A_CLKO, 8'h01);
    chk(pins, 8'h95);
    wr(`CPM_A_CLKO, 8'h00);
    chk(pins, 8'h85);
    // modem disable
    wr(`CPM_A_CTRL, 8'h01);
    chk(rfv, 8'h09);
    wr(`CPM_A_CTRL, 8'h00);
    chk(rfv, 8'h0f);
    // standby keeps contents, start-up on exit
    wr(`CPM_A_CMD, 8'h80);
    chk(pins, 8'h8a);
    chk(rfv, 8'h08);
    rd(`CPM_A_FB, d);
    chk(d, `CPM_FB_28);
    rd(`CPM_A_OUT, d);
    chk(d, 8'h3d);
    wr(`CPM_A_CMD, 8'h00);
    chk(pins, 8'h84);
    repeat (130) @(posedge clk_i);
    #1;
    chk({7'h00, ready_o}, 8'h00);
    wait_ready(40);
    // trim: measured count below target lowers trim by one
    wr(`CPM_A_LCTL, 8'h01);
    poll(1, 1'b1, 5);
    poll(1, 1'b0, 400);
    chk(trim_o, 8'h7f);
    // wake-up counter every reload+1 lfo edges
    wr(`CPM_A_WUC, 8'h03);
    wr(`CPM_A_LCTL, 8'h02);
    poll(2, 1'b1, 400);
    wr(`CPM_A_LCTL, 8'h00);
    wr(`CPM_A_STAT, 8'h04);
    rd(`CPM_A_STAT, d);
    chk(d, 8'h01);
    // timed wake from standby clears the request bit
    wr(`CPM_A_LCTL, 8'h06);
    wr(`CPM_A_CMD, 8'h80);
    chk(pins, 8'h8a);
    wait_ready(600);
    rd(`CPM_A_CMD, d);
    chk(d, 8'h00);
    wr(`CPM_A_LCTL, 8'h00);
    wr(`CPM_A_STAT, 8'h04);
    // short pin pulse ignored, long one powers down and resets
    @(posedge clk_i);
    pdn_i <= 1'b1;
    repeat (50) @(posedge clk_i);
    pdn_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    chk(pins, 8'h85);
    @(posedge clk_i);
    pdn_i <= 1'b1;
    repeat (90) @(posedge clk_i);
    #1;
    chk({7'h00, core_reg_on_o}, 8'h01);
    repeat (20) @(posedge clk_i);
    #1;
    chk(pins, 8'h60);
    chk(rfv, 8'h00);
    chk(fb_o, `CPM_RST_FB);
    rd(`CPM_A_FB, d);
    chk(d, 8'h00);
    @(posedge clk_i);
    pdn_i <= 1'b0;
    wait_ready(40);
    rd(`CPM_A_TRIM, d);
    chk(d, `CPM_RST_TRIM);
    rd(`CPM_A_OUT, d);
    chk(d, `CPM_RST_OUT);
    wrap_up();
  end
endmodule
